// ### verilog/disk_ctl_end.sv
// Controller end: software registers, turnaround timing, handshake
// Assumes the drive end on the same clock answers every handshake
//
// Our own choices: strobed register access and the register addresses.
`default_nettype none

module disk_ctl_end
	import disk_link_pkg::*;
#(
	parameter int CABLE_FT     = 150, // Cable length in feet
	parameter int CTRL_TURN_NS = 200, // Controller turnaround
	parameter int OCTET_CYC    = 2    // Clock cycles per octet
) (
	input  wire logic        clk_sys_i,
	input  wire logic        nrst_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic [31:0]      rdata_o,
	output logic             irq_o,
	disk_link_if.ctl_mp      lk
);

	// ------------------------------------------------------------
	// Turnaround budget
	// ------------------------------------------------------------
	localparam int CPD_NS = `XCVR_NS
		+ (`CABLE_NS_FT_X10 * CABLE_FT + 9) / 10;
	localparam int PROTO_NS = 8 * CPD_NS + 4 * CTRL_TURN_NS
		+ 2 * `DRV_TURN_OUT_NS + 2 * `DRV_TURN_NS;
	localparam int PROTO_CYC = (PROTO_NS + `CLK_NS - 1) / `CLK_NS;
	localparam int LOGIC_CYC = (`LOGIC_DELAY_NS + `CLK_NS - 1) / `CLK_NS;
	localparam logic [17:0] BASE_CYC = 18'(PROTO_CYC + LOGIC_CYC);

	generate
		if (CABLE_FT < 0 || CABLE_FT > 1000 || CTRL_TURN_NS < 0
			|| CTRL_TURN_NS > 10000)
		begin : g_bad
			$error("disk_ctl_end: cable or turnaround out of range");
		end
	endgenerate

	logic     tick; // One pulse per octet
	ctl_reg_t s, n; // Present and next state

	octet_tick #(
		.DIV (OCTET_CYC)
	) u_tick (
		.clk_sys_i (clk_sys_i),
		.nrst_i    (nrst_i),
		.tick_o    (tick)
	);

	// ------------------------------------------------------------
	// Registers, handshake and turnaround wait
	// ------------------------------------------------------------
	always_comb
	begin
		logic [1:0] set_v; // Events this cycle
		logic [1:0] clr_v; // Write-one-to-clear mask
		set_v = 2'h0;
		clr_v = 2'h0;
		n = s;
		n.rdata = 32'h0000_0000;

		// Software writes
		if (wr_i)
		begin
			case (addr_i)
				`REG_CTRL:
				begin
					if (wdata_i[`CTRL_GO_BIT] && !s.go)
					begin
						n.go   = 1'b1;
						n.code = wdata_i[7:0];
						n.head = wdata_i[`CTRL_HEAD_BIT];
					end
				end
				`REG_RECOV:   n.recov   = wdata_i[15:0];
				`REG_HSW:     n.hsw     = wdata_i[15:0];
				`REG_IRQ_ST:  clr_v     = wdata_i[1:0];
				`REG_IRQ_MSK: n.irq_msk = wdata_i[1:0];
				default:      n.rdata   = 32'h0000_0000;
			endcase
		end

		// Software reads, answered in the next cycle only
		if (rd_i)
		begin
			case (addr_i)
				`REG_CTRL:     n.rdata = {22'h0, s.go, s.head, s.code};
				`REG_RECOV:    n.rdata = {16'h0, s.recov};
				`REG_HSW:      n.rdata = {16'h0, s.hsw};
				`REG_IRQ_ST:   n.rdata = {30'h0, s.irq_st};
				`REG_IRQ_MSK:  n.rdata = {30'h0, s.irq_msk};
				`REG_BLK_HEAD: n.rdata = s.blk[63:32];
				`REG_BLK_TAIL: n.rdata = s.blk[31:0];
				`REG_TURN:     n.rdata = {16'h0, s.turn};
				default:       n.rdata = 32'h0000_0000;
			endcase
		end

		case (s.st)
			// Start once the drive offers ending status
			C_IDLE:
			begin
				if (s.go && lk.slave_end)
				begin
					n.turn = 16'h0000;
					n.wait_c = 18'h0;
					if (is_data(s.code))
					begin
						n.wait_c = BASE_CYC;
						if (s.prev_wr && s.code == `BC_READ)
							n.wait_c = n.wait_c + {2'h0, s.recov};
						if (s.head)
							n.wait_c = n.wait_c + {2'h0, s.hsw};
					end
					n.st = C_TURN;
				end
			end
			// Hold off and count the octets that pass meanwhile
			C_TURN:
			begin
				if (s.wait_c == 18'h0)
				begin
					n.sel = 1'b1;
					n.st  = C_SELECT;
				end
				else
				begin
					n.wait_c = s.wait_c - 1'b1;
					if (tick)
						n.turn = s.turn + 1'b1;
				end
			end
			C_SELECT:
			begin
				if (lk.slave_ack)
				begin
					n.bctl     = 1'b1;
					n.bus_a    = s.code;
					n.turn_out = s.turn;
					n.st       = C_BUSCTL;
				end
			end
			C_BUSCTL:
			begin
				if (lk.bus_ack)
				begin
					n.bctl = 1'b0;
					n.mast = 1'b1;
					n.st   = C_MASTEND;
				end
			end
			C_MASTEND:
			begin
				if (lk.slave_ack)
				begin
					n.mast = 1'b0;
					n.sel  = 1'b0;
					n.bidx = 3'h0;
					n.st   = C_XFER;
				end
			end
			// Gather status bytes until ending status returns
			C_XFER:
			begin
				if (lk.bstb)
				begin
					n.blk[8 * (7 - s.bidx) +: 8] = lk.bus_b;
					n.bidx = s.bidx + 1'b1;
					// Reserved positions are not looked at
					if (s.bidx == 3'h0 && s.code == `BC_STATUS
						&& lk.bus_b[6:0] != 7'h00)
						set_v[`IRQ_EXC_BIT] = 1'b1;
				end
				if (lk.slave_end)
				begin
					n.prev_wr = (s.code == `BC_WRITE);
					n.go = 1'b0;
					set_v[`IRQ_DONE_BIT] = 1'b1;
					n.st = C_IDLE;
				end
			end
			default:
				n.st = C_IDLE;
		endcase

		// A new event wins over a clear in the same cycle
		n.irq_st = (s.irq_st & ~clr_v) | set_v;
		n.irq    = |(n.irq_st & n.irq_msk);
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
		begin
			s         <= '0;
			s.st      <= C_IDLE;
			s.recov   <= `RST_RECOV;
			s.hsw     <= `RST_HSW;
			s.irq_msk <= `RST_IRQ_MSK;
		end
		else
			s <= n;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign rdata_o  = s.rdata;
	assign irq_o    = s.irq;
	assign lk.sel   = s.sel;
	assign lk.mast  = s.mast;
	assign lk.bctl  = s.bctl;
	assign lk.bus_a = s.bus_a;
	assign lk.turn  = s.turn_out;

endmodule

`default_nettype wire

// ### verilog/disk_link_regs.svh
// Constants shared by both ends of the drive link: codes, masks, times
// Assumes inclusion by bare name from the package and the bench
`ifndef DISK_LINK_REGS_SVH
`define DISK_LINK_REGS_SVH

// ----------------------------------------------------------------
// Bus control codes carried on bus A
// ----------------------------------------------------------------
`define BC_STATUS        8'h01
`define BC_EXT_STATUS    8'h02
`define BC_READ          8'h10
`define BC_WRITE         8'h11

// ----------------------------------------------------------------
// Status block layout
// ----------------------------------------------------------------
`define BLK_BYTES        8
`define BCX_INVALID_BIT  7
// Defined positions per byte; every other bit is reserved (zero)
`define UNSOL_MASK       8'hF7
`define BCX_MASK         8'hF8
`define DX0_MASK         8'hE6
`define DX1_MASK         8'hB8
`define DX2_MASK         8'hE0
`define RECV_MASK        8'hFB
`define DCTL_MASK        8'hC0
`define DSTAT_MASK       8'hC3
`define ALARM_MASK       8'h26

// ----------------------------------------------------------------
// Gap and turnaround timing
// ----------------------------------------------------------------
`define IFACE_DELAY_OCT  2
`define WR_DELAY_OCT     3
`define CLK_NS           100
`define XCVR_NS          59
`define CABLE_NS_FT_X10  19
`define DRV_TURN_OUT_NS  250
`define DRV_TURN_NS      350
`define LOGIC_DELAY_NS   3100

// ----------------------------------------------------------------
// Controller register byte offsets and reset values
// ----------------------------------------------------------------
`define REG_CTRL         8'h00
`define REG_RECOV        8'h04
`define REG_HSW          8'h08
`define REG_IRQ_ST       8'h0C
`define REG_IRQ_MSK      8'h10
`define REG_BLK_HEAD     8'h14
`define REG_BLK_TAIL     8'h18
`define REG_TURN         8'h1C
`define CTRL_HEAD_BIT    8
`define CTRL_GO_BIT      9
`define IRQ_DONE_BIT     0
`define IRQ_EXC_BIT      1
`define RST_RECOV        16'h0000
`define RST_HSW          16'h0000
`define RST_IRQ_MSK      2'h0

`endif

// ### verilog/disk_link_pkg.sv
// Types shared by the drive end and the controller end
// Assumes the constants header sits in the include path
`default_nettype none
`include "disk_link_regs.svh"

package disk_link_pkg;

	// ------------------------------------------------------------
	// Drive end
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		D_SLAVEND, D_SLAVACK1, D_BUSACK, D_SLAVACK2,
		D_XFRRDY, D_SEND, D_FIELD, D_GAP
	} dev_state_t;

	typedef struct packed {
		dev_state_t  st;
		logic [7:0]  cmd;
		logic [15:0] turn;
		logic [16:0] cnt;
		logic [2:0]  idx;
		logic [7:0]  bcx;
		logic        slave_end;
		logic        slave_ack;
		logic        bus_ack;
		logic [7:0]  bus_b;
		logic        bstb;
		logic        field;
		logic        write;
		logic        gap;
	} dev_reg_t;

	// ------------------------------------------------------------
	// Controller end
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		C_IDLE, C_TURN, C_SELECT, C_BUSCTL, C_MASTEND, C_XFER
	} ctl_state_t;

	typedef struct packed {
		ctl_state_t  st;
		logic [7:0]  code;
		logic        go;
		logic        head;
		logic        prev_wr;
		logic [17:0] wait_c;
		logic [15:0] turn;
		logic [15:0] recov;
		logic [15:0] hsw;
		logic [63:0] blk;
		logic [2:0]  bidx;
		logic [1:0]  irq_st;
		logic [1:0]  irq_msk;
		logic [31:0] rdata;
		logic        irq;
		logic        sel;
		logic        mast;
		logic        bctl;
		logic [7:0]  bus_a;
		logic [15:0] turn_out;
	} ctl_reg_t;

	// True for codes that move a data field
	function automatic logic is_data(input logic [7:0] c);
		return (c == `BC_READ) || (c == `BC_WRITE);
	endfunction

	// True for every code the drive understands
	function automatic logic is_known(input logic [7:0] c);
		return is_data(c) || (c == `BC_STATUS) || (c == `BC_EXT_STATUS);
	endfunction

endpackage

`default_nettype wire

// ### verilog/disk_link_if.sv
// Link between the controller and the drive, both on clk_sys_i
// Assumes the bench resolves nothing: every signal has one driver
`default_nettype none

interface disk_link_if;
	logic        sel;        // Controller select
	logic        mast;       // Controller master end
	logic        bctl;       // Bus control valid on bus_a
	logic [7:0]  bus_a;      // Bus control code
	logic [15:0] turn;       // Turnaround octets of this control
	logic        slave_end;  // Drive ending status ready
	logic        slave_ack;  // Drive acknowledge
	logic        bus_ack;    // Drive took the bus control
	logic [7:0]  bus_b;      // Status byte from the drive
	logic        bstb;       // Status byte strobe, one cycle

	modport dev_mp (
		input  sel, mast, bctl, bus_a, turn,
		output slave_end, slave_ack, bus_ack, bus_b, bstb
	);
	modport ctl_mp (
		output sel, mast, bctl, bus_a, turn,
		input  slave_end, slave_ack, bus_ack, bus_b, bstb
	);
endinterface

`default_nettype wire

// ### verilog/octet_tick.sv
// Octet-rate enable: one-cycle pulse every DIV clocks
// Assumes a single system clock and synchronous active-low reset
`default_nettype none

module octet_tick #(
	parameter int DIV = 2
) (
	input  wire logic clk_sys_i,
	input  wire logic nrst_i,
	output logic      tick_o
);
	localparam int W = $clog2(DIV + 1);

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	generate
		if (DIV < 1)
		begin : g_bad
			$error("octet_tick: DIV must be at least 1");
		end
	endgenerate

	typedef struct packed {
		logic [W-1:0] cnt;  // Cycles left to the next pulse
		logic         tick; // Registered pulse
	} tick_reg_t;

	tick_reg_t s, n;

	// Count down and pulse on wrap
	always_comb
	begin
		n = s;
		n.tick = 1'b0;
		if (s.cnt == '0)
		begin
			n.cnt = W'(DIV - 1);
			n.tick = 1'b1;
		end
		else
			n.cnt = s.cnt - 1'b1;
	end

	// State register
	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
			s <= '0;
		else
			s <= n;
	end

	assign tick_o = s.tick;
endmodule

`default_nettype wire

// ### verilog/disk_drive_end.sv
// Drive end of the link: control handshake, status blocks, field gaps
// Assumes the controller end on the same clock keeps its own timing
`default_nettype none

module disk_drive_end
	import disk_link_pkg::*;
#(
	parameter int HSC_OCT   = 4,   // Head scatter in octets
	parameter int FIELD_OCT = 256, // Octets in one data field
	parameter int OCTET_CYC = 2    // Clock cycles per octet
) (
	input  wire logic        clk_sys_i,
	input  wire logic        nrst_i,
	disk_link_if.dev_mp      lk,
	input  wire logic [4:0]  fault_i,
	input  wire logic [7:0]  unsol_i,
	input  wire logic [23:0] drv_exc_i,
	input  wire logic        port_num_i,
	input  wire logic        alt_port_en_i,
	input  wire logic        reserve_act_i,
	input  wire logic        completion_irq_enable_i,
	input  wire logic        rotational_position_irq_enable_i,
	input  wire logic        pending_report_irq_enable_i,
	input  wire logic        format_spec_present_i,
	input  wire logic [7:0]  recv_flags_i,
	input  wire logic [7:0]  drive_ctl_i,
	input  wire logic [7:0]  drive_stat_i,
	input  wire logic [7:0]  alarms_i,
	output logic             field_active_o,
	output logic             field_write_o,
	output logic             gap_active_o
);

	// ------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------
	generate
		if (HSC_OCT < 0 || HSC_OCT > 1000)
		begin : g_bad_hsc
			$error("disk_drive_end: HSC_OCT out of range");
		end
		if (FIELD_OCT < 1 || FIELD_OCT > 65535)
		begin : g_bad_field
			$error("disk_drive_end: FIELD_OCT out of range");
		end
	endgenerate

	// Internal delay added to every gap
	localparam logic [16:0] MIN_GAP =
		17'(2 * HSC_OCT + `IFACE_DELAY_OCT + `WR_DELAY_OCT);
	localparam logic [16:0] FIELD_LEN = 17'(FIELD_OCT);

	// ------------------------------------------------------------
	// Octet timing
	// ------------------------------------------------------------
	logic tick; // One pulse per octet

	octet_tick #(
		.DIV (OCTET_CYC)
	) u_tick (
		.clk_sys_i (clk_sys_i),
		.nrst_i    (nrst_i),
		.tick_o    (tick)
	);

	// ------------------------------------------------------------
	// Status blocks, built live from the drive's own state
	// ------------------------------------------------------------
	dev_reg_t   s, n;                // Present and next state
	logic [7:0] sb [`BLK_BYTES];     // Status response block
	logic [7:0] eb [`BLK_BYTES];     // Extended status block
	logic [7:0] unsol_m;             // Unsolicited byte, masked
	logic [7:0] bcx_m;               // Bus control byte, masked

	assign unsol_m = unsol_i & `UNSOL_MASK;
	assign bcx_m   = s.bcx & `BCX_MASK;

	// Byte 0 summarises bytes 1 and 2 so the controller can flag an exception from it
	assign sb[0] = {1'b1, |unsol_m, |bcx_m, fault_i};
	assign sb[1] = unsol_m;
	assign sb[2] = bcx_m;
	assign sb[3] = drv_exc_i[23:16] & `DX0_MASK;
	assign sb[4] = drv_exc_i[15:8] & `DX1_MASK;
	assign sb[5] = drv_exc_i[7:0] & `DX2_MASK;
	assign sb[6] = 8'h00;
	assign sb[7] = 8'h00;

	// Flags byte in fixed order, extended status on top
	assign eb[0] = {1'b1, port_num_i, alt_port_en_i, reserve_act_i,
		completion_irq_enable_i, rotational_position_irq_enable_i,
		pending_report_irq_enable_i, format_spec_present_i};
	assign eb[1] = recv_flags_i & `RECV_MASK;
	assign eb[2] = drive_ctl_i & `DCTL_MASK;
	assign eb[3] = drive_stat_i & `DSTAT_MASK;
	assign eb[4] = alarms_i & `ALARM_MASK;
	// Vendor bytes carry nothing here
	assign eb[5] = 8'h00;
	assign eb[6] = 8'h00;
	assign eb[7] = 8'h00;

	// ------------------------------------------------------------
	// Handshake, transfer and gap sequencing
	// ------------------------------------------------------------
	// The drive waits in D_SLAVEND, D_SLAVACK1 and D_BUSACK for the controller's
	// next move; no timeout, since the controller owns the pace.
	always_comb
	begin
		n = s;
		n.bstb = 1'b0;
		case (s.st)
			// Ending status offered, wait for select
			D_SLAVEND:
			begin
				if (lk.sel)
					n.st = D_SLAVACK1;
			end
			// Select acknowledged, wait for the bus control
			D_SLAVACK1:
			begin
				if (lk.bctl)
				begin
					n.cmd  = lk.bus_a;
					n.turn = lk.turn;
					if (!is_known(lk.bus_a))
						n.bcx[`BCX_INVALID_BIT] = 1'b1;
					n.st = D_BUSACK;
				end
			end
			// Bus control taken, wait for master end
			D_BUSACK:
			begin
				if (lk.mast)
					n.st = D_SLAVACK2;
			end
			// Final acknowledge, one cycle
			D_SLAVACK2:
				n.st = D_XFRRDY;
			// Transfer ready: start what the control asked for
			D_XFRRDY:
			begin
				n.idx = 3'h0;
				if (is_data(s.cmd))
				begin
					n.cnt = FIELD_LEN;
					n.st  = D_FIELD;
				end
				else if (is_known(s.cmd))
					n.st = D_SEND;
				else
					n.st = D_SLAVEND; // Rejected, end at once
			end
			// One status byte per octet time
			D_SEND:
			begin
				if (tick)
				begin
					n.bstb  = 1'b1;
					n.bus_b = (s.cmd == `BC_EXT_STATUS) ? eb[s.idx] : sb[s.idx];
					n.idx   = s.idx + 1'b1;
					if (s.idx == 3'h7)
					begin
						// Reported once, so the exception is spent
						if (s.cmd == `BC_STATUS)
							n.bcx = 8'h00;
						n.st = D_SLAVEND;
					end
				end
			end
			// Data field passes under the head
			D_FIELD:
			begin
				if (tick)
				begin
					if (s.cnt <= 17'h00001)
					begin
						// Turnaround may be zero; internal part stays
						n.cnt = MIN_GAP + {1'b0, s.turn};
						n.st  = D_GAP;
					end
					else
						n.cnt = s.cnt - 1'b1;
				end
			end
			// Gap keeps the write splice out of the next field
			D_GAP:
			begin
				if (tick)
				begin
					if (s.cnt <= 17'h00001)
						n.st = D_SLAVEND;
					else
						n.cnt = s.cnt - 1'b1;
				end
			end
			default:
				n.st = D_SLAVEND;
		endcase

		// Outputs follow the next state so they leave flip-flops
		n.slave_end = (n.st == D_SLAVEND);
		n.slave_ack = (n.st == D_SLAVACK1) || (n.st == D_SLAVACK2);
		n.bus_ack   = (n.st == D_BUSACK);
		n.field     = (n.st == D_FIELD);
		n.write     = (n.st == D_FIELD) && (n.cmd == `BC_WRITE);
		n.gap       = (n.st == D_GAP);
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Reset lands in ending status so the first control can start
	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
		begin
			s           <= '0;
			s.st        <= D_SLAVEND;
			s.slave_end <= 1'b1;
		end
		else
			s <= n;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign lk.slave_end   = s.slave_end;
	assign lk.slave_ack   = s.slave_ack;
	assign lk.bus_ack     = s.bus_ack;
	assign lk.bus_b       = s.bus_b;
	assign lk.bstb        = s.bstb;
	assign field_active_o = s.field;
	assign field_write_o  = s.write;
	assign gap_active_o   = s.gap;

endmodule

`default_nettype wire

// ### tb/disk_link_assertions.sv
// Checker for the link between controller end and drive end
// Assumes one clock and a synchronous active-low reset
`default_nettype none

module disk_link_assertions
	import disk_link_pkg::*;
(
	input wire logic        clk_sys_i,
	input wire logic        nrst_i,
	input wire logic        sel,
	input wire logic        mast,
	input wire logic        bctl,
	input wire logic [7:0]  bus_a,
	input wire logic [15:0] turn,
	input wire logic        slave_end,
	input wire logic        slave_ack,
	input wire logic        bus_ack,
	input wire logic [7:0]  bus_b,
	input wire logic        bstb
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------
	// Clock and steps of the exchange
	// ----------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);

	// Master end acknowledged, then the controller lets go
	sequence s_close;
		slave_ack ##1 (!mast && !sel);
	endsequence
	// Eight status bytes, then ending status again
	sequence s_block;
		bstb [*8] ##1 (!bstb && slave_end);
	endsequence

	chk_select_ack: assert property ($rose(sel) |=> slave_ack && !slave_end)
		else $error("select not acknowledged");
	chk_busctl_ack: assert property ($rose(bctl) |=> bus_ack && !slave_ack)
		else $error("bus control not taken");
	chk_ack_mast: assert property ($rose(bus_ack) |=> mast && !bctl)
		else $error("master end late");
	chk_mast_close: assert property ($rose(mast) |=> s_close)
		else $error("exchange not closed");
	chk_bctl_in_sel: assert property (bctl |-> sel)
		else $error("bus control outside select");
	chk_code_stable: assert property (bctl && !bus_ack |=> $stable(bus_a))
		else $error("code changed before ack");
	chk_idle_quiet: assert property (slave_end |-> !slave_ack && !bus_ack)
		else $error("ack while ending status");
	chk_block_len: assert property ($rose(bstb) |-> s_block)
		else $error("status block length wrong");
	chk_turn_zero: assert property ($rose(bctl) && !is_data(bus_a) |-> turn == 16'h0000)
		else $error("turnaround on non-data control");
	// First byte of either block always carries its top flag
	chk_block_head: assert property ($rose(bstb) |-> bus_b[7])
		else $error("first block byte lacks top flag");
endmodule

`default_nettype wire

// ### tb/disk_field_gap_status_report_tb.sv
// Bench joining controller end and drive end through the link
// Assumes the shared header is in the include path
`default_nettype none
`include "disk_link_regs.svh"

module disk_field_gap_status_report_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import disk_link_pkg::*;
	// ----------------------------------------------------------
	// Expected timing from the cable and turnaround figures
	// ----------------------------------------------------------
	localparam int CPD   = `XCVR_NS + (`CABLE_NS_FT_X10 * 150) / 10;
	localparam int PNS   = 8 * CPD + 4 * 200 + 2 * `DRV_TURN_OUT_NS + 2 * `DRV_TURN_NS;
	localparam int PROTO = (PNS + `CLK_NS - 1) / `CLK_NS;
	localparam int LOGIC = `LOGIC_DELAY_NS / `CLK_NS;

	logic        clk_sys_i = 1'b0;
	logic        nrst_i    = 1'b0;
	logic [7:0]  addr_i    = 8'h00;
	logic [31:0] wdata_i   = 32'h0;
	logic        wr_i      = 1'b0;
	logic        rd_i      = 1'b0;
	logic [31:0] rdata_o;
	logic        irq_o;
	logic        fa_o, fw_o, ga_o;
	logic        fa_q = 1'b0, ga_q = 1'b0, bc_q = 1'b0, fwr = 1'b0;
	logic [15:0] seen_turn = 16'h0, tw;
	logic [31:0] rv;
	int          fcnt = 0, flen = 0, gcnt = 0, glen = 0;
	// Drive-side state inputs, changed by the tests
	logic [4:0]  flt = 5'h15;
	logic [6:0]  ifl = 7'h66;
	logic [23:0] dx  = 24'hFFFFFF;
	logic [7:0]  un = 8'hFF, rf = 8'hFF, dc = 8'hFF, ds = 8'hFF, al = 8'hFF;
	int          mismatches = 0;
	int          check_count = 0;

	always #50 clk_sys_i = ~clk_sys_i;

	disk_link_if lk ();
	disk_ctl_end #(.OCTET_CYC(1)) i_disk_ctl_end (
		.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .lk(lk));
	// Field of 8 octets, one octet per clock, so counts equal cycles
	disk_drive_end #(.HSC_OCT(1), .FIELD_OCT(8), .OCTET_CYC(1)) i_disk_drive_end (
		.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .lk(lk), .fault_i(flt),
		.unsol_i(un), .drv_exc_i(dx), .port_num_i(ifl[6]),
		.alt_port_en_i(ifl[5]), .reserve_act_i(ifl[4]), .completion_irq_enable_i(ifl[3]),
		.rotational_position_irq_enable_i(ifl[2]), .pending_report_irq_enable_i(ifl[1]),
		.format_spec_present_i(ifl[0]), .recv_flags_i(rf), .drive_ctl_i(dc),
		.drive_stat_i(ds), .alarms_i(al), .field_active_o(fa_o),
		.field_write_o(fw_o), .gap_active_o(ga_o));
	disk_link_assertions i_disk_link_assertions (
		.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .sel(lk.sel), .mast(lk.mast),
		.bctl(lk.bctl), .bus_a(lk.bus_a), .turn(lk.turn), .slave_end(lk.slave_end),
		.slave_ack(lk.slave_ack), .bus_ack(lk.bus_ack), .bus_b(lk.bus_b), .bstb(lk.bstb));

	// Monitor: turnaround at bus control, field and gap lengths
	always @(posedge clk_sys_i)
	begin
		bc_q <= lk.bctl;
		fa_q <= fa_o;
		ga_q <= ga_o;
		if (lk.bctl && !bc_q)
			seen_turn <= lk.turn;
		if (fa_o && !fa_q)
			fwr <= fw_o;
		fcnt <= fa_o ? fcnt + 1 : 0;
		gcnt <= ga_o ? gcnt + 1 : 0;
		if (fa_q && !fa_o)
			flen <= fcnt;
		if (ga_q && !ga_o)
			glen <= gcnt;
	end

	// ----------------------------------------------------------
	// Access tasks and comparison
	// ----------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1 rv = rdata_o;
		if (what != "")
			chk(what, rv, exp);
	endtask
	task automatic irqchk(input logic exp);
		@(posedge clk_sys_i);
		#1 chk("interrupt", {31'h0, irq_o}, {31'h0, exp});
	endtask
	// Start a control and poll busy, bounded so a hang is reported
	task automatic run(input logic [7:0] code, input logic head);
		int n;
		n = 0;
		wr(`REG_CTRL, {22'h0, 1'b1, head, code});
		rv = 32'h200;
		while (rv[`CTRL_GO_BIT] !== 1'b0 && n < 3000)
		begin
			rchk("", `REG_CTRL, 32'h0);
			n++;
		end
		if (n >= 3000)
			chk("busy", rv, 32'h0);
		repeat (3) @(posedge clk_sys_i);
	endtask
	task automatic results();
		$display("checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Watchdog far beyond the expected run length
	initial
	begin
		repeat (40000) @(posedge clk_sys_i);
		mismatches++;
		results();
	end

	// ----------------------------------------------------------
	// Tests
	// ----------------------------------------------------------
	initial
	begin
		repeat (3) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		rchk("recovery", `REG_RECOV, 32'h0);
		rchk("mask", `REG_IRQ_MSK, 32'h0);
		wr(8'h40, 32'hFFFF_FFFF);
		rchk("unmapped", 8'h40, 32'h0);
		$display("test reset done");
		wr(`REG_IRQ_MSK, 32'h3);
		run(`BC_STATUS, 1'b0);
		rchk("status head", `REG_BLK_HEAD, 32'hD5F7_00E6);
		rchk("status tail", `REG_BLK_TAIL, 32'hB8E0_0000);
		rchk("irq status", `REG_IRQ_ST, 32'h3);
		irqchk(1'b1);
		wr(`REG_IRQ_MSK, 32'h0);
		irqchk(1'b0);
		wr(`REG_IRQ_MSK, 32'h2);
		irqchk(1'b1);
		wr(`REG_IRQ_ST, 32'h3);
		irqchk(1'b0);
		$display("test status done");
		run(`BC_EXT_STATUS, 1'b0);
		rchk("ext head", `REG_BLK_HEAD, 32'hE6FB_C0C3);
		rchk("ext tail", `REG_BLK_TAIL, 32'h2600_0000);
		$display("test extended done");
		// Refused code flags the next status block only
		run(8'h33, 1'b0);
		run(`BC_STATUS, 1'b0);
		rchk("refused head", `REG_BLK_HEAD, 32'hF5F7_80E6);
		run(`BC_STATUS, 1'b0);
		rchk("cleared head", `REG_BLK_HEAD, 32'hD5F7_00E6);
		$display("test refused done");
		wr(`REG_RECOV, 32'd5);
		wr(`REG_HSW, 32'd7);
		run(`BC_WRITE, 1'b0);
		tw = seen_turn;
		chk("write turn", 32'(tw), 32'(PROTO + LOGIC));
		chk("field", 32'(flen), 32'd8);
		chk("write flag", {31'h0, fwr}, 32'h1);
		chk("gap", 32'(glen), 32'(2 + `IFACE_DELAY_OCT + `WR_DELAY_OCT + tw));
		rchk("turn reg", `REG_TURN, 32'(tw));
		run(`BC_READ, 1'b1);
		chk("read turn", 32'(seen_turn), 32'(tw) + 32'd12);
		chk("read flag", {31'h0, fwr}, 32'h0);
		run(`BC_STATUS, 1'b0);
		chk("status turn", 32'(seen_turn), 32'h0);
		$display("test data done");
		// Only reserved positions set, flags the inverse of before
		{flt, un, dx, ifl} <= {5'h0A, 8'h08, 24'h19471F, 7'h19};
		{rf, dc, ds, al} <= 32'h043F_3CD9;
		run(`BC_STATUS, 1'b0);
		rchk("spare head", `REG_BLK_HEAD, 32'h8A00_0000);
		rchk("spare tail", `REG_BLK_TAIL, 32'h0);
		run(`BC_EXT_STATUS, 1'b0);
		rchk("spare ext head", `REG_BLK_HEAD, 32'h9900_0000);
		rchk("spare ext tail", `REG_BLK_TAIL, 32'h0);
		$display("test reserved done");
		results();
	end
endmodule

`default_nettype wire
